// ==== inc/timer8_pkg.sv ====
// Purpose: shared constants and carriers for the 8-bit timer/event counter
// Assumes: byte-wide register port, 16-bit register addresses
// Notes: all offsets, field positions, reset values and divider masks live here
package timer8_pkg;

	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_INPUT_SWITCH = 16'hFF4F; // input switch control
	localparam logic [15:0] ADDR_MODE_CONTROL = 16'hFF5C; // third counter mode control
	localparam logic [15:0] ADDR_CLOCK_SELECT = 16'hFF5D; // count clock / edge select
	localparam logic [15:0] ADDR_COMPARE = 16'hFF5E; // compare value
	localparam logic [15:0] ADDR_COUNT = 16'hFF5F; // live count, read only

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int MODE_RUN_BIT = 7; // run control
	localparam int MODE_SET_BIT = 3; // write-only: set output flip-flop
	localparam int MODE_CLR_BIT = 2; // write-only: clear output flip-flop
	localparam int MODE_INV_BIT = 1; // toggle on match
	localparam int MODE_OE_BIT = 0; // output enable
	localparam int ISC_FIELD_MSB = 5; // top stored bit of input switch
	localparam int CLK_SEL_MSB = 2; // top stored bit of clock select

	// ----------------------------------------------------------------
	// reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] RESET_BYTE = 8'h00; // all control registers
	localparam logic [4:0] PIN_RESET_LEVEL = 5'h06; // receive pins idle high
	localparam logic [1:0] PAIR_FIRST = 2'h0; // first tx/rx pin pair
	localparam logic [1:0] PAIR_ALT = 2'h1; // alternate tx/rx pin pair
	localparam logic [2:0] CLK_EVENT_FALL = 3'h0; // external falling edge
	localparam logic [2:0] CLK_EVENT_RISE = 3'h1; // external rising edge
	localparam logic [2:0] CLK_DIV1 = 3'h2; // every core cycle
	localparam logic [2:0] CLK_DIV2 = 3'h3;
	localparam logic [2:0] CLK_DIV16 = 3'h4;
	localparam logic [2:0] CLK_DIV64 = 3'h5;
	localparam logic [2:0] CLK_DIV256 = 3'h6;
	localparam logic [2:0] CLK_DIV4096 = 3'h7;

	// ----------------------------------------------------------------
	// prescaler masks: tick when masked bits of the prescaler are all ones
	// ----------------------------------------------------------------
	localparam int PRESCALE_WIDTH = 12;
	localparam logic [11:0] MASK_DIV1 = 12'h000;
	localparam logic [11:0] MASK_DIV2 = 12'h001;
	localparam logic [11:0] MASK_DIV16 = 12'h00F;
	localparam logic [11:0] MASK_DIV64 = 12'h03F;
	localparam logic [11:0] MASK_DIV256 = 12'h0FF;
	localparam logic [11:0] MASK_DIV4096 = 12'hFFF;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic run; // counting enabled
		logic invert; // toggle output on match
		logic out_enable; // drive the timer output pin
	} mode_control_s;

	typedef struct packed {
		logic [1:0] serial_pair_sel; // hi, lo
		logic alt_receive_enable; // pass first-pair receive pin
		logic event_gate_select; // gate event input by companion timer
		logic capture_source_select; // capture from receive pin
		logic ext_irq_source_select; // irq zero from receive pin
	} input_switch_s;

endpackage : timer8_pkg

// ==== verilog/pin_sync_filter.sv ====
// Purpose: three-stage synchroniser with agreement filter and edge pulses
// Assumes: inputs asynchronous to the core clock
// Notes: a change is accepted once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync_filter #(
	parameter int WIDTH = 5,
	parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// raw pins
	input wire logic [WIDTH-1:0] i_pin,
	// filtered level and edges
	output logic [WIDTH-1:0] o_level,
	output logic [WIDTH-1:0] o_rise,
	output logic [WIDTH-1:0] o_fall
);

	logic [WIDTH-1:0] stage1_reg; // metastable stage, read only by stage2
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] level_reg; // accepted level
	logic [WIDTH-1:0] rise_reg;
	logic [WIDTH-1:0] fall_reg;

	// ----------------------------------------------------------------
	// per-pin chain
	// ----------------------------------------------------------------
	for (genvar b = 0; b < WIDTH; b++) begin : g_pin
		// shift chain and agreement filter
		always_ff @(posedge i_clk) begin
			if (!i_rst_n) begin
				stage1_reg[b] <= RESET_LEVEL[b];
				stage2_reg[b] <= RESET_LEVEL[b];
				stage3_reg[b] <= RESET_LEVEL[b];
				level_reg[b] <= RESET_LEVEL[b];
				rise_reg[b] <= 1'b0;
				fall_reg[b] <= 1'b0;
			end else begin
				stage1_reg[b] <= i_pin[b];
				stage2_reg[b] <= stage1_reg[b];
				stage3_reg[b] <= stage2_reg[b];
				// accept only when the last two stages agree
				if (stage2_reg[b] == stage3_reg[b]) begin
					level_reg[b] <= stage3_reg[b];
				end
				rise_reg[b] <= (stage2_reg[b] == stage3_reg[b]) & stage3_reg[b] & ~level_reg[b];
				fall_reg[b] <= (stage2_reg[b] == stage3_reg[b]) & ~stage3_reg[b] & level_reg[b];
			end
		end
	end

	assign o_level = level_reg;
	assign o_rise = rise_reg;
	assign o_fall = fall_reg;

endmodule : pin_sync_filter
`default_nettype wire

// ==== verilog/timer_event_counter8.sv ====
// Purpose: 8-bit timer / event counter with input switch routing
// Assumes: byte register port on the core clock, pins asynchronous
// Notes: counter clears on compare match; square wave on the output pin
//
// Overview of operation
// - run 0 clears and stops; 1 starts
// - gate select lets companion timer gate events
// - pair field picks first or alternate pins
// - receive enable passes first-pair receive pin; clear blocks it
// - capture source: dedicated pin or receive pin
// - irq zero source: own pin or receive
// - input switch resets zero, top bits zero
// - match clears counter, keeps counting, interrupts
// - three-bit field chooses clock or edge
// - event mode: falling 00H, rising 01H
// - compare accepts full byte range
// - output toggles on match: 50% square
// - output low while output disabled
// - square period is twice (N+1) counts
`timescale 1ns/1ps
`default_nettype none
module timer_event_counter8 (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	// register port
	input wire logic [15:0] I_REG_ADDR,
	input wire logic I_REG_WR,
	input wire logic [7:0] I_REG_WDATA,
	output logic [7:0] O_REG_RDATA,
	// external pins
	input wire logic I_EVENT_INPUT_PIN,
	input wire logic I_SERIAL_RECEIVE_PIN0,
	input wire logic I_SERIAL_RECEIVE_PIN1,
	input wire logic I_CAPTURE_PIN,
	input wire logic I_EXTERNAL_IRQ_ZERO_PIN,
	// on-chip sources
	input wire logic I_GATING_TIMER_OUTPUT,
	input wire logic I_SERIAL_TRANSMIT,
	// timer outputs
	output logic O_TIMER_OUTPUT_PIN,
	output logic O_MATCH_IRQ,
	// routed signals
	output logic O_SERIAL_RECEIVE,
	output logic O_CAPTURE_INPUT,
	output logic O_EXTERNAL_IRQ_ZERO,
	output logic O_SERIAL_TRANSMIT_PIN0,
	output logic O_SERIAL_TRANSMIT_PIN1
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	timer8_pkg::mode_control_s mode_reg; // run, invert, output enable
	timer8_pkg::input_switch_s isc_reg; // routing controls
	logic [2:0] clock_select_reg; // count source
	logic [7:0] compare_reg; // match value
	logic [7:0] count_reg; // live count
	logic [11:0] prescale_reg; // internal divider
	logic toggle_reg; // output flip-flop
	logic irq_reg; // match pulse
	logic [7:0] rdata_reg; // read data
	logic [4:0] pin_level; // filtered pins
	logic [4:0] pin_rise;
	logic [4:0] pin_fall;
	logic [11:0] prescale_mask; // selected divider mask
	logic event_mode; // external edge selected
	logic event_gate_open; // companion gate state
	logic count_tick; // one-cycle count enable
	logic match_hit; // count equals compare on a tick
	logic rx_first; // first-pair receive after enable
	logic mode_wr; // write strobe to mode register

	// ----------------------------------------------------------------
	// pin synchronisers: 0 event, 1 rx0, 2 rx1, 3 capture, 4 irq zero
	// ----------------------------------------------------------------
	pin_sync_filter #(
		.WIDTH(5),
		.RESET_LEVEL(timer8_pkg::PIN_RESET_LEVEL)
	) u_sync (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_pin({I_EXTERNAL_IRQ_ZERO_PIN, I_CAPTURE_PIN, I_SERIAL_RECEIVE_PIN1,
			I_SERIAL_RECEIVE_PIN0, I_EVENT_INPUT_PIN}),
		.o_level(pin_level),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	assign mode_wr = I_REG_WR && (I_REG_ADDR == timer8_pkg::ADDR_MODE_CONTROL);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// register writes; low mode bits other than toggle/output are not stored
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			mode_reg <= '0;
			isc_reg <= '0;
			clock_select_reg <= timer8_pkg::RESET_BYTE[2:0];
			compare_reg <= timer8_pkg::RESET_BYTE;
		end else if (I_REG_WR) begin
			unique case (I_REG_ADDR)
				timer8_pkg::ADDR_MODE_CONTROL: begin
					mode_reg.run <= I_REG_WDATA[timer8_pkg::MODE_RUN_BIT];
					mode_reg.invert <= I_REG_WDATA[timer8_pkg::MODE_INV_BIT];
					mode_reg.out_enable <= I_REG_WDATA[timer8_pkg::MODE_OE_BIT];
				end
				timer8_pkg::ADDR_INPUT_SWITCH: begin
					isc_reg <= I_REG_WDATA[timer8_pkg::ISC_FIELD_MSB:0];
				end
				timer8_pkg::ADDR_CLOCK_SELECT: begin
					clock_select_reg <= I_REG_WDATA[timer8_pkg::CLK_SEL_MSB:0];
				end
				timer8_pkg::ADDR_COMPARE: begin
					compare_reg <= I_REG_WDATA;
				end
				default: begin
					// count is read only; unmapped writes are dropped
				end
			endcase
		end
	end

	// read data, one cycle after the address; unmapped reads give zero
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			rdata_reg <= timer8_pkg::RESET_BYTE;
		end else begin
			unique case (I_REG_ADDR)
				timer8_pkg::ADDR_MODE_CONTROL: rdata_reg <= {mode_reg.run, 5'h00,
					mode_reg.invert, mode_reg.out_enable};
				timer8_pkg::ADDR_INPUT_SWITCH: rdata_reg <= {2'h0, isc_reg};
				timer8_pkg::ADDR_CLOCK_SELECT: rdata_reg <= {5'h00, clock_select_reg};
				timer8_pkg::ADDR_COMPARE: rdata_reg <= compare_reg;
				timer8_pkg::ADDR_COUNT: rdata_reg <= count_reg;
				default: rdata_reg <= timer8_pkg::RESET_BYTE;
			endcase
		end
	end

	assign O_REG_RDATA = rdata_reg;

	// ----------------------------------------------------------------
	// count source
	// ----------------------------------------------------------------
	// divider mask; the edge codes leave the prescaler unused
	always_comb begin
		prescale_mask = timer8_pkg::MASK_DIV1;
		unique case (clock_select_reg)
			timer8_pkg::CLK_DIV2: prescale_mask = timer8_pkg::MASK_DIV2;
			timer8_pkg::CLK_DIV16: prescale_mask = timer8_pkg::MASK_DIV16;
			timer8_pkg::CLK_DIV64: prescale_mask = timer8_pkg::MASK_DIV64;
			timer8_pkg::CLK_DIV256: prescale_mask = timer8_pkg::MASK_DIV256;
			timer8_pkg::CLK_DIV4096: prescale_mask = timer8_pkg::MASK_DIV4096;
			default: prescale_mask = timer8_pkg::MASK_DIV1;
		endcase
	end

	assign event_mode = (clock_select_reg == timer8_pkg::CLK_EVENT_FALL) ||
		(clock_select_reg == timer8_pkg::CLK_EVENT_RISE);
	// companion timer only matters when gating is selected
	assign event_gate_open = !isc_reg.event_gate_select || I_GATING_TIMER_OUTPUT;

	// one tick per selected edge or per divided internal period
	always_comb begin
		count_tick = 1'b0;
		if (!mode_reg.run) begin
			count_tick = 1'b0;
		end else if (clock_select_reg == timer8_pkg::CLK_EVENT_FALL) begin
			count_tick = pin_fall[0] && event_gate_open;
		end else if (clock_select_reg == timer8_pkg::CLK_EVENT_RISE) begin
			count_tick = pin_rise[0] && event_gate_open;
		end else begin
			count_tick = ((prescale_reg & prescale_mask) == prescale_mask);
		end
	end

	assign match_hit = count_tick && (count_reg == compare_reg);

	// prescaler restarts with the counter, so the first period is full
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N || !mode_reg.run) begin
			prescale_reg <= '0;
		end else begin
			prescale_reg <= prescale_reg + 12'h001;
		end
	end

	// ----------------------------------------------------------------
	// counter and match pulse
	// ----------------------------------------------------------------
	// stopped counter sits at zero, so a restart counts from zero
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N || !mode_reg.run) begin
			count_reg <= 8'h00;
		end else if (match_hit) begin
			count_reg <= 8'h00;
		end else if (count_tick) begin
			count_reg <= count_reg + 8'h01;
		end
	end

	// pulse lands in the cycle the count shows zero after the wrap
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= match_hit;
		end
	end

	assign O_MATCH_IRQ = irq_reg;

	// ----------------------------------------------------------------
	// output flip-flop
	// ----------------------------------------------------------------
	// software set/clear wins over a same-cycle match toggle
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			toggle_reg <= 1'b0;
		end else if (mode_wr && I_REG_WDATA[timer8_pkg::MODE_SET_BIT] &&
			!I_REG_WDATA[timer8_pkg::MODE_CLR_BIT]) begin
			toggle_reg <= 1'b1;
		end else if (mode_wr && I_REG_WDATA[timer8_pkg::MODE_CLR_BIT] &&
			!I_REG_WDATA[timer8_pkg::MODE_SET_BIT]) begin
			toggle_reg <= 1'b0;
		end else if (match_hit && mode_reg.invert) begin
			toggle_reg <= !toggle_reg;
		end
	end

	assign O_TIMER_OUTPUT_PIN = mode_reg.out_enable && toggle_reg;

	// ----------------------------------------------------------------
	// input switch routing
	// ----------------------------------------------------------------
	// blocked receive idles high so a uart sees no start bit
	assign rx_first = isc_reg.alt_receive_enable ? pin_level[1] : 1'b1;
	assign O_SERIAL_RECEIVE = (isc_reg.serial_pair_sel == timer8_pkg::PAIR_ALT) ?
		pin_level[2] : rx_first;
	assign O_SERIAL_TRANSMIT_PIN0 = (isc_reg.serial_pair_sel == timer8_pkg::PAIR_ALT) ?
		1'b1 : I_SERIAL_TRANSMIT;
	assign O_SERIAL_TRANSMIT_PIN1 = (isc_reg.serial_pair_sel == timer8_pkg::PAIR_ALT) ?
		I_SERIAL_TRANSMIT : 1'b1;
	assign O_CAPTURE_INPUT = isc_reg.capture_source_select ? O_SERIAL_RECEIVE :
		pin_level[3];
	assign O_EXTERNAL_IRQ_ZERO = isc_reg.ext_irq_source_select ? O_SERIAL_RECEIVE :
		pin_level[4];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);

	stop_clears_a: assert property (!mode_reg.run |=> count_reg == 8'h00)
		else $error("count not zero while stopped");
	match_wrap_a: assert property (match_hit |=> (count_reg == 8'h00) && O_MATCH_IRQ)
		else $error("match did not wrap with interrupt");
	irq_single_a: assert property (O_MATCH_IRQ && compare_reg != 8'h00 |=> !O_MATCH_IRQ)
		else $error("match pulse longer than one cycle");
	count_step_a: assert property (count_tick && !match_hit && mode_reg.run |=>
		count_reg == $past(count_reg) + 8'h01)
		else $error("count did not step on tick");
	gate_block_a: assert property (mode_reg.run && event_mode &&
		isc_reg.event_gate_select && !I_GATING_TIMER_OUTPUT |=> $stable(count_reg))
		else $error("gated event input still counted");
	rise_edge_a: assert property (mode_reg.run &&
		clock_select_reg == timer8_pkg::CLK_EVENT_RISE && !pin_rise[0] |=>
		$stable(count_reg))
		else $error("rising edge mode counted without edge");
	toggle_match_a: assert property (match_hit && mode_reg.invert && !mode_wr |=>
		toggle_reg != $past(toggle_reg))
		else $error("output did not toggle on match");
	out_low_a: assert property (!mode_reg.out_enable |-> !O_TIMER_OUTPUT_PIN)
		else $error("output pin high while disabled");
	isc_read_a: assert property (I_REG_ADDR == timer8_pkg::ADDR_INPUT_SWITCH |=>
		O_REG_RDATA[7:6] == 2'h0)
		else $error("input switch upper bits not zero");
	rx_block_a: assert property (isc_reg.serial_pair_sel != timer8_pkg::PAIR_ALT &&
		!isc_reg.alt_receive_enable |-> O_SERIAL_RECEIVE)
		else $error("blocked receive pin passed through");
	capture_src_a: assert property (isc_reg.capture_source_select |->
		O_CAPTURE_INPUT == O_SERIAL_RECEIVE)
		else $error("capture not from receive pin");
	irq_src_a: assert property (!isc_reg.ext_irq_source_select |->
		O_EXTERNAL_IRQ_ZERO == pin_level[4])
		else $error("irq zero not from own pin");

	square_wave_c: cover property (match_hit && mode_reg.invert && mode_reg.out_enable);
	event_match_c: cover property (match_hit && event_mode);
	gated_event_c: cover property (event_mode && isc_reg.event_gate_select && pin_rise[0]);
	alt_pair_c: cover property (isc_reg.serial_pair_sel == timer8_pkg::PAIR_ALT &&
		isc_reg.capture_source_select);

endmodule : timer_event_counter8
`default_nettype wire

// ==== test/event_source_model.sv ====
// Purpose: event pulse source standing on the far side of the event pin
// Assumes: same clock as the timer, requests made after a falling edge
// Notes: pin idles low between bursts; half period set per burst
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// burst request
	input wire logic i_start,
	input wire logic [7:0] i_count,
	input wire logic [7:0] i_half,
	// pin and status
	output logic o_event_pin,
	output logic o_busy
);
	logic [7:0] left_reg; // halves still to send
	logic [7:0] tick_reg; // cycles spent in this half
	// ----------------------------------------------------------------
	// burst engine: a slow half keeps the filter from eating pulses
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_event_pin <= 1'b0; // pin acts as an input to the timer
			o_busy <= 1'b0;
			left_reg <= 8'h00;
			tick_reg <= 8'h00;
		end else if (i_start && !o_busy) begin
			left_reg <= {i_count[6:0], 1'b0}; // two halves per pulse
			tick_reg <= 8'h00;
			o_busy <= (i_count != 8'h00);
		end else if (o_busy) begin
			if (tick_reg == i_half - 8'h01) begin
				tick_reg <= 8'h00;
				o_event_pin <= ~o_event_pin; // one rise and one fall per pulse
				left_reg <= left_reg - 8'h01;
				o_busy <= (left_reg != 8'h01);
			end else begin
				tick_reg <= tick_reg + 8'h01;
			end
		end
	end
endmodule : event_source_model
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the 8-bit timer / event counter
// Assumes: inputs driven at the falling edge, outputs sampled there too, except the irq tally, taken at the rising edge
// Notes: software ordering is kept by the bench: stop, configure, run
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk, rst_n, wr, ev_pin, rx0, rx1, cap, irqp, gate, tx;
	logic to_pin, irq, rx_o, cap_o, irq_o, tx0, tx1, ev_start, ev_busy;
	logic [15:0] addr; // register address
	logic [7:0] wdata, rdata, ev_count, ev_half;
	int fail_count, n_compared, cycles, irq_total;
	timer_event_counter8 u_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REG_ADDR(addr),
		.I_REG_WR(wr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_EVENT_INPUT_PIN(ev_pin),
		.I_SERIAL_RECEIVE_PIN0(rx0), .I_SERIAL_RECEIVE_PIN1(rx1), .I_CAPTURE_PIN(cap),
		.I_EXTERNAL_IRQ_ZERO_PIN(irqp), .I_GATING_TIMER_OUTPUT(gate),
		.I_SERIAL_TRANSMIT(tx), .O_TIMER_OUTPUT_PIN(to_pin), .O_MATCH_IRQ(irq),
		.O_SERIAL_RECEIVE(rx_o), .O_CAPTURE_INPUT(cap_o), .O_EXTERNAL_IRQ_ZERO(irq_o),
		.O_SERIAL_TRANSMIT_PIN0(tx0), .O_SERIAL_TRANSMIT_PIN1(tx1));
	event_source_model u_src (.i_clk(clk), .i_rst_n(rst_n), .i_start(ev_start),
		.i_count(ev_count), .i_half(ev_half), .o_event_pin(ev_pin), .o_busy(ev_busy));
	// ----------------------------------------------------------------
	// clock, watchdog and interrupt tally
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (irq === 1'b1) irq_total++; // pulses seen since time zero
		if (cycles == 20000) begin
			fail_count++;
			$display("Error at %0t: run hung", $time);
			tally_and_finish();
		end
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk_byte
	task automatic chk_count(input int got, input int exp, input string what);
		n_compared++;
		if (got != exp) begin
			fail_count++;
			$display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask : chk_count
	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : reg_wr
	// read data is registered, so let two edges pass with the address held
	task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		repeat (2) @(negedge clk);
		d = rdata;
	endtask : reg_rd
	// negedges until the next pulse, width check, then the pulse spacing
	task automatic irq_gap(output int first, output int n);
		first = 0;
		while (irq !== 1'b1 && first < 5000) begin
			@(negedge clk);
			first++;
		end
		@(negedge clk);
		chk_byte({7'h00, irq}, 8'h00, "irq pulse width");
		n = 1;
		while (irq !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
	endtask : irq_gap
	// configure while stopped, then run; the stop also clears the count
	task automatic setup(input logic [7:0] sel, input logic [7:0] cmp, input logic [7:0] mode);
		reg_wr(timer8_pkg::ADDR_MODE_CONTROL, 8'h00);
		reg_wr(timer8_pkg::ADDR_CLOCK_SELECT, sel);
		reg_wr(timer8_pkg::ADDR_COMPARE, cmp);
		reg_wr(timer8_pkg::ADDR_MODE_CONTROL, mode);
	endtask : setup
	task automatic fire(input logic [7:0] n);
		@(negedge clk);
		ev_count = n;
		ev_half = 8'h08;
		ev_start = 1'b1;
		@(negedge clk);
		ev_start = 1'b0;
		for (int k = 0; k < 5000 && ev_busy; k++) @(negedge clk);
		repeat (8) @(negedge clk); // filter latency
	endtask : fire
	task automatic route(input logic [7:0] input_switch_control, input logic [4:0] pins, input logic [4:0] exp);
		reg_wr(timer8_pkg::ADDR_INPUT_SWITCH, input_switch_control);
		{rx0, rx1, cap, irqp, tx} = pins;
		repeat (6) @(negedge clk);
		chk_byte({3'h0, rx_o, cap_o, irq_o, tx0, tx1}, {3'h0, exp}, "routing");
	endtask : route
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		logic [7:0] d;
		reg_rd(timer8_pkg::ADDR_INPUT_SWITCH, d);
		chk_byte(d, 8'h00, "switch reset");
		chk_byte({6'h00, to_pin, irq}, 8'h00, "idle outputs");
		reg_wr(timer8_pkg::ADDR_INPUT_SWITCH, 8'hDF);
		reg_rd(timer8_pkg::ADDR_INPUT_SWITCH, d);
		chk_byte(d, 8'h1F, "switch top bits");
		$display("test regs done");
	endtask : t_regs
	task automatic t_route;
		route(8'h00, 5'h00, 5'h11); // receive blocked, own pins
		route(8'h08, 5'h07, 5'h0F); // first pair passes receive
		route(8'h0B, 5'h06, 5'h01); // capture and irq from receive
		route(8'h13, 5'h16, 5'h02); // alternate pair selected
		reg_wr(timer8_pkg::ADDR_INPUT_SWITCH, 8'h00);
		$display("test route done");
	endtask : t_route
	task automatic t_interval;
		int f, g;
		logic [7:0] d;
		setup(8'h02, 8'h02, 8'h80);
		irq_gap(f, g);
		chk_count(f, 3, "first match delay");
		chk_count(g, 3, "match interval");
		irq_gap(f, g);
		chk_count(f + g, 3, "repeat interval");
		reg_wr(timer8_pkg::ADDR_MODE_CONTROL, 8'h00);
		reg_rd(timer8_pkg::ADDR_COUNT, d);
		chk_byte(d, 8'h00, "stopped count");
		// two ticks per match with compare one: interval is twice the divide ratio
		for (int i = 0; i < 5; i++) begin
			setup(8'h02 + 8'(i), 8'h01, 8'h80);
			irq_gap(f, g);
			chk_count(g, (i == 0) ? 2 : (i == 1) ? 4 : (i == 2) ? 32 : (i == 3) ? 128 : 512,
				"divided interval");
		end
		$display("test interval done");
	endtask : t_interval
	task automatic t_square;
		int h, l;
		setup(8'h02, 8'h03, 8'h03);
		reg_wr(timer8_pkg::ADDR_MODE_CONTROL, 8'h83);
		for (int k = 0; k < 50 && to_pin !== 1'b1; k++) @(negedge clk);
		for (h = 0; h < 50 && to_pin === 1'b1; h++) @(negedge clk);
		for (l = 0; l < 50 && to_pin === 1'b0; l++) @(negedge clk);
		chk_count(h, 4, "high half");
		chk_count(l, 4, "low half");
		reg_wr(timer8_pkg::ADDR_MODE_CONTROL, 8'h00);
		repeat (10) @(negedge clk);
		chk_byte({7'h00, to_pin}, 8'h00, "disabled output");
		// preset and clear of the output flip-flop while stopped
		reg_wr(timer8_pkg::ADDR_MODE_CONTROL, 8'h09);
		chk_byte({7'h00, to_pin}, 8'h01, "preset output");
		reg_wr(timer8_pkg::ADDR_MODE_CONTROL, 8'h05);
		chk_byte({7'h00, to_pin}, 8'h00, "cleared output");
		reg_wr(timer8_pkg::ADDR_MODE_CONTROL, 8'h00);
		$display("test square done");
	endtask : t_square
	task automatic t_event;
		int i0;
		logic [7:0] d;
		setup(8'h01, 8'h04, 8'h80); // toggle and output off
		i0 = irq_total;
		fire(8'h05);
		chk_count(irq_total - i0, 1, "event match");
		reg_rd(timer8_pkg::ADDR_COUNT, d);
		chk_byte(d, 8'h00, "count after match");
		setup(8'h00, 8'h04, 8'h80);
		fire(8'h03);
		reg_rd(timer8_pkg::ADDR_COUNT, d);
		chk_byte(d, 8'h03, "falling edges");
		reg_wr(timer8_pkg::ADDR_INPUT_SWITCH, 8'h04);
		setup(8'h01, 8'h04, 8'h80);
		gate = 1'b0;
		fire(8'h03);
		reg_rd(timer8_pkg::ADDR_COUNT, d);
		chk_byte(d, 8'h00, "gated events");
		gate = 1'b1;
		fire(8'h02);
		reg_rd(timer8_pkg::ADDR_COUNT, d);
		chk_byte(d, 8'h02, "open gate");
		$display("test event done");
	endtask : t_event
	task automatic tally_and_finish;
		$display("Counts: %0d compared, %0d mismatched", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		// write strobe low, receive pins idle high
		{rst_n, wr, rx0, rx1, cap, irqp, gate, tx, ev_start} = 9'h060;
		{addr, wdata, ev_count, ev_half} = 40'h0;
		fail_count = 0;
		n_compared = 0;
		cycles = 0;
		irq_total = 0;
		repeat (3) @(negedge clk); // synchronous reset, three edges
		rst_n = 1'b1;
		t_regs();
		t_route();
		t_interval();
		t_square();
		t_event();
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
